// file: design/hacp_consts.svh
`ifndef HACP_CONSTS_SVH
`define HACP_CONSTS_SVH

// ---------------------------------------------------------------
// port offsets (io_addr)
// ---------------------------------------------------------------
`define HACP_OFS_CTRL_STAT 2'h0
`define HACP_OFS_CMD_DATA 2'h1
`define HACP_OFS_INT_FLAG 2'h2

// ---------------------------------------------------------------
// control port bits (write, offset 0)
// ---------------------------------------------------------------
`define HACP_CTL_HARD_RST 7
`define HACP_CTL_SOFT_RST 6
`define HACP_CTL_INT_RST 5
`define HACP_CTL_BUS_RST 4

// ---------------------------------------------------------------
// status port bits (read, offset 0)
// ---------------------------------------------------------------
`define HACP_ST_SELF_TEST 7
`define HACP_ST_DIAG_FAIL 6
`define HACP_ST_INIT_REQ 5
`define HACP_ST_IDLE 4
`define HACP_ST_CMD_FULL 3
`define HACP_ST_DIN_FULL 2
`define HACP_ST_INVALID 0

// ---------------------------------------------------------------
// interrupt flag port bits (read, offset 2)
// ---------------------------------------------------------------
`define HACP_IF_ANY 7
`define HACP_IF_BUS_RST_DET 3
`define HACP_IF_CMD_DONE 2

// ---------------------------------------------------------------
// named opcodes; all but nop get special handling
// ---------------------------------------------------------------
`define HACP_OP_NOP 8'h00
`define HACP_OP_MBX_INIT 8'h01
`define HACP_OP_START_BUS 8'h02
`define HACP_OP_INQUIRY 8'h04
`define HACP_OP_ECHO 8'h1F
`define HACP_OP_START_BIOS 8'h82

// ---------------------------------------------------------------
// inquiry reply bytes (values arbitrary)
// ---------------------------------------------------------------
`define HACP_INQ_BOARD 8'h5A
`define HACP_INQ_OPTION 8'h30
`define HACP_INQ_REV_HI 8'h31
`define HACP_INQ_REV_LO 8'h30

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HACP_CLK_MHZ 25
`define HACP_TAKE_MAX_US 100
`define HACP_TAKE_MAX_CYC (`HACP_TAKE_MAX_US * `HACP_CLK_MHZ)
`define HACP_DONE_MAX_US 200
`define HACP_DONE_MAX_CYC (`HACP_DONE_MAX_US * `HACP_CLK_MHZ)
`define HACP_BUS_RST_US 25
`define HACP_BUS_RST_CYC (`HACP_BUS_RST_US * `HACP_CLK_MHZ)
`define HACP_RST_CNT_W 10

`endif

// file: design/hacp_pkg.sv
`default_nettype none
package hacp_pkg;
  typedef logic [7:0] hacp_byte_t;
  typedef logic [2:0] hacp_nparam_t;
  typedef logic [3:0] hacp_nret_t;
  // interpreter states, gray along idle-param-exec-return
  typedef enum logic [1:0] {
    HACP_IDLE = 2'b00,
    HACP_PARAM = 2'b01,
    HACP_EXEC = 2'b11,
    HACP_RET = 2'b10
  } hacp_state_t;
endpackage
`default_nettype wire

// file: design/hacp_len_rom.sv
`include "hacp_consts.svh"
`default_nettype none
// opcode length table: fixed outbound and returned byte counts per opcode
module hacp_len_rom (
  input wire hacp_pkg::hacp_byte_t opcode, // opcode under decode
  output logic known, // opcode is supported
  output hacp_pkg::hacp_nparam_t nparam, // outbound parameter bytes
  output hacp_pkg::hacp_nret_t nret // returned bytes
);
  import hacp_pkg::*;

  // ---------------------------------------------------------------
  // decode table
  // ---------------------------------------------------------------
  always_comb begin
    known = 1'b1;
    nparam = 3'h0;
    nret = 4'h0;
    case (opcode)
      8'h00, 8'h02, 8'h03, 8'h20, 8'h25, 8'h26, 8'h27, 8'h82: begin
      end
      8'h01, 8'h06: nparam = 3'h4;
      8'h04: nret = 4'h4;
      8'h05, 8'h07, 8'h08, 8'h09, 8'h24: nparam = 3'h1;
      8'h0A: nret = 4'h8;
      8'h0B: nret = 4'h3;
      8'h0C, 8'h21, 8'h29: nparam = 3'h2;
      8'h0D: begin
        nparam = 3'h1;
        nret = 4'h4;
      end
      8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h22, 8'h23: nparam = 3'h3;
      8'h1F: begin
        nparam = 3'h1;
        nret = 4'h1;
      end
      8'h28: nret = 4'h2;
      default: known = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: design/hacp_core.sv
`include "hacp_consts.svh"
`default_nettype none
module hacp_core (
  input wire logic ref_clk, // adapter clock, 25 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic [1:0] io_addr, // host port offset
  input wire logic io_wr, // host write strobe, one cycle
  input wire logic io_rd, // host read strobe, one cycle
  input wire hacp_pkg::hacp_byte_t io_wdata, // host write data
  output hacp_pkg::hacp_byte_t io_rdata, // host read data, valid cycle after io_rd
  input wire logic bus_rst_in, // bus reset line level seen on the bus
  input wire logic phase_err, // phase error recovery request, pulse
  output logic bus_rst_drive, // drive bus reset line
  output logic host_irq, // host interrupt level
  output logic ccb_abandon, // pulse: discard all pending control blocks
  output logic start_bus_cmd, // pulse: begin mailbox-out scan
  output logic start_bios_cmd // pulse: begin bios bus command
);
  import hacp_pkg::*;

  hacp_state_t state, next_state;
  hacp_byte_t cmd_byte, next_cmd_byte;
  hacp_byte_t opcode, next_opcode;
  hacp_byte_t param0, next_param0;
  hacp_byte_t din, next_din;
  hacp_byte_t next_io_rdata;
  hacp_nparam_t pcnt, next_pcnt;
  hacp_nret_t rcnt, next_rcnt;
  logic [`HACP_RST_CNT_W-1:0] rst_cnt, next_rst_cnt;
  logic cmd_full, next_cmd_full;
  logic din_full, next_din_full;
  logic cmd_done, next_cmd_done;
  logic bus_det, next_bus_det;
  logic invalid, next_invalid;
  logic init_req, next_init_req;
  logic self_test, next_self_test;
  logic mbx_ready, next_mbx_ready;
  logic bus_rst_q, next_bus_rst_q;
  logic next_bus_rst_drive, next_host_irq, next_ccb_abandon;
  logic next_start_bus, next_start_bios;
  logic known;
  hacp_nparam_t nparam, op_nparam;
  hacp_nret_t nret, op_nret;
  logic wr_ctl, wr_cmd, rd_din, bus_edge;

  // ---------------------------------------------------------------
  // opcode length lookup, for new opcode and running command
  // ---------------------------------------------------------------
  hacp_len_rom u_new (
    .opcode(cmd_byte),
    .known(known),
    .nparam(nparam),
    .nret(nret)
  );

  hacp_len_rom u_run (
    .opcode(opcode),
    .known(),
    .nparam(op_nparam),
    .nret(op_nret)
  );

  // host strobes decoded per port
  assign wr_ctl = io_wr && (io_addr == `HACP_OFS_CTRL_STAT);
  assign wr_cmd = io_wr && (io_addr == `HACP_OFS_CMD_DATA);
  assign rd_din = io_rd && (io_addr == `HACP_OFS_CMD_DATA);
  // reset edge from another device; our own drive excluded
  assign bus_edge = bus_rst_in && !bus_rst_q && !bus_rst_drive;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cmd_byte = cmd_byte;
    next_opcode = opcode;
    next_param0 = param0;
    next_din = din;
    next_pcnt = pcnt;
    next_rcnt = rcnt;
    next_rst_cnt = rst_cnt;
    next_cmd_full = cmd_full;
    next_din_full = din_full;
    next_cmd_done = cmd_done;
    next_bus_det = bus_det;
    next_invalid = invalid;
    next_init_req = init_req;
    next_self_test = self_test;
    next_mbx_ready = mbx_ready;
    next_bus_rst_q = bus_rst_in;
    next_ccb_abandon = 1'b0;
    next_start_bus = 1'b0;
    next_start_bios = 1'b0;
    next_io_rdata = io_rdata;

    // host read of data-in empties it
    if (rd_din) begin
      next_din_full = 1'b0;
    end
    // interrupt reset from control port
    if (wr_ctl && io_wdata[`HACP_CTL_INT_RST]) begin
      next_cmd_done = 1'b0;
      next_bus_det = 1'b0;
      next_invalid = 1'b0;
    end

    // command byte port; a write while full is dropped
    if (wr_cmd && !cmd_full) begin
      next_cmd_byte = io_wdata;
      next_cmd_full = 1'b1;
    end

    // interpreter
    case (state)
      HACP_IDLE: begin
        if (cmd_full && !self_test) begin
          next_cmd_full = 1'b0;
          next_opcode = cmd_byte;
          next_pcnt = 3'h0;
          next_rcnt = 4'h0;
          if (!known) begin
            next_cmd_done = 1'b1;
            next_invalid = 1'b1;
          end else if (nparam != 3'h0) begin
            next_state = HACP_PARAM;
          end else begin
            next_state = HACP_EXEC;
          end
        end
      end
      HACP_PARAM: begin
        if (cmd_full) begin
          next_cmd_full = 1'b0;
          if (pcnt == 3'h0) begin
            next_param0 = cmd_byte;
          end
          next_pcnt = pcnt + 3'h1;
          if (pcnt + 3'h1 == op_nparam) begin
            next_state = HACP_EXEC;
          end
        end
      end
      HACP_EXEC: begin
        next_state = (op_nret != 4'h0) ? HACP_RET : HACP_IDLE;
        if (opcode == `HACP_OP_START_BUS || opcode == `HACP_OP_START_BIOS) begin
          // start commands raise no completion unless refused
          if (!mbx_ready) begin
            next_cmd_done = 1'b1;
            next_invalid = 1'b1;
          end else if (opcode == `HACP_OP_START_BUS) begin
            next_start_bus = 1'b1;
          end else begin
            next_start_bios = 1'b1;
          end
        end else if (opcode == `HACP_OP_MBX_INIT) begin
          next_cmd_done = 1'b1;
          if (param0 == 8'h00) begin
            next_invalid = 1'b1;
          end else begin
            next_mbx_ready = 1'b1;
            next_init_req = 1'b0;
          end
        end else if (op_nret == 4'h0) begin
          next_cmd_done = 1'b1;
        end
      end
      HACP_RET: begin
        if (!din_full) begin
          if (rcnt == op_nret) begin
            next_cmd_done = 1'b1;
            next_state = HACP_IDLE;
          end else begin
            next_rcnt = rcnt + 4'h1;
            next_din_full = 1'b1;
            if (opcode == `HACP_OP_ECHO) begin
              next_din = param0;
            end else if (opcode == `HACP_OP_INQUIRY) begin
              case (rcnt[1:0])
                2'h0: next_din = `HACP_INQ_BOARD;
                2'h1: next_din = `HACP_INQ_OPTION;
                2'h2: next_din = `HACP_INQ_REV_HI;
                default: next_din = `HACP_INQ_REV_LO;
              endcase
            end else begin
              next_din = 8'h00;
            end
          end
        end
      end
      default: next_state = HACP_IDLE;
    endcase

    // bus reset drive timer: host request or phase error recovery
    if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - `HACP_RST_CNT_W'(1);
    end else begin
      next_self_test = 1'b0;
    end
    if (wr_ctl && io_wdata[`HACP_CTL_BUS_RST]) begin
      next_rst_cnt = `HACP_RST_CNT_W'(`HACP_BUS_RST_CYC);
    end
    // only soft style on bus reset: pending work kept, host flagged
    if (bus_edge || phase_err) begin
      next_bus_det = 1'b1;
    end
    if (phase_err) begin
      next_rst_cnt = `HACP_RST_CNT_W'(`HACP_BUS_RST_CYC);
    end

    // controller soft reset: drop blocks and setup, no bus reset
    if (wr_ctl && io_wdata[`HACP_CTL_SOFT_RST]) begin
      next_ccb_abandon = 1'b1;
      next_mbx_ready = 1'b0;
      next_init_req = 1'b1;
      next_state = HACP_IDLE;
      next_cmd_full = 1'b0;
      next_din_full = 1'b0;
      next_start_bus = 1'b0;
      next_start_bios = 1'b0;
    end

    // full hard reset: bus reset plus self test, blocks dropped, setup, interrupt and full flags cleared
    if (wr_ctl && io_wdata[`HACP_CTL_HARD_RST]) begin
      next_rst_cnt = `HACP_RST_CNT_W'(`HACP_BUS_RST_CYC);
      next_ccb_abandon = 1'b1;
      next_mbx_ready = 1'b0;
      next_init_req = 1'b1;
      next_self_test = 1'b1;
      next_state = HACP_IDLE;
      next_cmd_full = 1'b0;
      next_din_full = 1'b0;
      next_cmd_done = 1'b0;
      next_bus_det = 1'b0;
      next_invalid = 1'b0;
      next_start_bus = 1'b0;
      next_start_bios = 1'b0;
    end

    next_bus_rst_drive = (next_rst_cnt != '0);
    next_host_irq = next_cmd_done || next_bus_det;

    // registered read data
    if (io_rd) begin
      if (io_addr == `HACP_OFS_CTRL_STAT) begin
        next_io_rdata = 8'h00;
        next_io_rdata[`HACP_ST_SELF_TEST] = self_test;
        next_io_rdata[`HACP_ST_INIT_REQ] = init_req;
        next_io_rdata[`HACP_ST_IDLE] = (state == HACP_IDLE) && !self_test && !cmd_full;
        next_io_rdata[`HACP_ST_CMD_FULL] = cmd_full;
        next_io_rdata[`HACP_ST_DIN_FULL] = din_full;
        next_io_rdata[`HACP_ST_INVALID] = invalid;
      end else if (io_addr == `HACP_OFS_CMD_DATA) begin
        next_io_rdata = din;
      end else if (io_addr == `HACP_OFS_INT_FLAG) begin
        next_io_rdata = 8'h00;
        next_io_rdata[`HACP_IF_ANY] = cmd_done || bus_det;
        next_io_rdata[`HACP_IF_BUS_RST_DET] = bus_det;
        next_io_rdata[`HACP_IF_CMD_DONE] = cmd_done;
      end else begin
        next_io_rdata = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= HACP_IDLE;
      cmd_byte <= 8'h00;
      opcode <= 8'h00;
      param0 <= 8'h00;
      din <= 8'h00;
      pcnt <= 3'h0;
      rcnt <= 4'h0;
      rst_cnt <= `HACP_RST_CNT_W'(`HACP_BUS_RST_CYC);
      cmd_full <= 1'b0;
      din_full <= 1'b0;
      cmd_done <= 1'b0;
      bus_det <= 1'b0;
      invalid <= 1'b0;
      init_req <= 1'b1;
      self_test <= 1'b1;
      mbx_ready <= 1'b0;
      bus_rst_q <= 1'b1;
      bus_rst_drive <= 1'b1;
      host_irq <= 1'b0;
      ccb_abandon <= 1'b0;
      start_bus_cmd <= 1'b0;
      start_bios_cmd <= 1'b0;
      io_rdata <= 8'h00;
    end else begin
      state <= next_state;
      cmd_byte <= next_cmd_byte;
      opcode <= next_opcode;
      param0 <= next_param0;
      din <= next_din;
      pcnt <= next_pcnt;
      rcnt <= next_rcnt;
      rst_cnt <= next_rst_cnt;
      cmd_full <= next_cmd_full;
      din_full <= next_din_full;
      cmd_done <= next_cmd_done;
      bus_det <= next_bus_det;
      invalid <= next_invalid;
      init_req <= next_init_req;
      self_test <= next_self_test;
      mbx_ready <= next_mbx_ready;
      bus_rst_q <= next_bus_rst_q;
      bus_rst_drive <= next_bus_rst_drive;
      host_irq <= next_host_irq;
      ccb_abandon <= next_ccb_abandon;
      start_bus_cmd <= next_start_bus;
      start_bios_cmd <= next_start_bios;
      io_rdata <= next_io_rdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/hacp_core_checker.sv
`include "hacp_consts.svh"
`default_nettype none
// watches the host ports and bus reset pins of the command core
module hacp_core_checker (
  input wire logic ref_clk, // adapter clock
  input wire logic nrst, // reset, active low
  input wire logic [1:0] io_addr, // port offset
  input wire logic io_wr, // write strobe
  input wire logic io_rd, // read strobe
  input wire hacp_pkg::hacp_byte_t io_wdata, // write data
  input wire hacp_pkg::hacp_byte_t io_rdata, // read data
  input wire logic bus_rst_in, // bus reset level
  input wire logic phase_err, // phase error pulse
  input wire logic bus_rst_drive, // bus reset drive
  input wire logic host_irq, // host interrupt
  input wire logic ccb_abandon, // discard pulse
  input wire logic start_bus_cmd, // mailbox scan pulse
  input wire logic start_bios_cmd // bios command pulse
);
  import hacp_pkg::*;
  hacp_byte_t last_cmd, next_last_cmd;
  logic [10:0] hi_cnt, next_hi_cnt;
  logic ctl_wr, cmd_wr;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // decode host writes to control and command ports
  assign ctl_wr = io_wr && (io_addr == `HACP_OFS_CTRL_STAT);
  assign cmd_wr = io_wr && (io_addr == `HACP_OFS_CMD_DATA);
  // last command byte and length of the current drive span
  always_comb begin
    next_last_cmd = cmd_wr ? io_wdata : last_cmd;
    next_hi_cnt = bus_rst_drive ? hi_cnt + 11'h001 : 11'h000;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_cmd <= 8'h00;
      hi_cnt <= 11'h000;
    end else begin
      last_cmd <= next_last_cmd;
      hi_cnt <= next_hi_cnt;
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  soft_abandon_a: assert property (ctl_wr && (io_wdata[6] || io_wdata[7]) |=> ccb_abandon)
    else $error("no discard pulse after reset request");
  abandon_pulse_a: assert property (ccb_abandon |=> !ccb_abandon)
    else $error("discard pulse longer than one cycle");
  soft_quiet_a: assert property (
    ctl_wr && io_wdata[6] && !io_wdata[7] && !io_wdata[4] && !bus_rst_drive && !phase_err
    |=> (!bus_rst_drive) [*8]) else $error("soft reset drove the bus reset");
  hard_drive_a: assert property (ctl_wr && io_wdata[7] |-> ##[1:2] bus_rst_drive)
    else $error("hard reset did not drive bus reset");
  drive_len_a: assert property ($fell(bus_rst_drive) |-> hi_cnt >= 11'h270)
    else $error("bus reset drive too short");
  foreign_irq_a: assert property (
    $rose(bus_rst_in) && !bus_rst_drive && !$past(bus_rst_drive) |-> ##[1:4] host_irq)
    else $error("foreign bus reset not signalled");
  bus_start_a: assert property (
    start_bus_cmd |-> (last_cmd == `HACP_OP_START_BUS) ##1 !start_bus_cmd)
    else $error("bad mailbox scan pulse");
  bios_start_a: assert property (
    start_bios_cmd |-> (last_cmd == `HACP_OP_START_BIOS) ##1 !start_bios_cmd)
    else $error("bad bios command pulse");
  rdata_hold_a: assert property (
    !io_rd && !ctl_wr && !$past(ctl_wr) |=> $stable(io_rdata))
    else $error("read data changed without a read");
endmodule
bind hacp_core hacp_core_checker chk_u (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .bus_rst_in(bus_rst_in), .phase_err(phase_err), .bus_rst_drive(bus_rst_drive),
  .host_irq(host_irq), .ccb_abandon(ccb_abandon), .start_bus_cmd(start_bus_cmd),
  .start_bios_cmd(start_bios_cmd));
`default_nettype wire

// file: bench/hacp_bus_dev.sv
`default_nettype none
// another device on the bus that can pull the wired-or reset line
module hacp_bus_dev (
  input wire logic ref_clk, // adapter clock
  input wire logic bus_rst_drive, // reset driven by the core
  input wire logic fire, // start a foreign reset
  output logic bus_rst_in // wired-or reset line level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;
  // hold the line for twelve cycles once fired
  always_ff @(posedge ref_clk) begin
    if (fire) left <= 4'hC;
    else if (left != 4'h0) left <= left - 4'h1;
  end
  assign bus_rst_in = bus_rst_drive || (left != 4'h0);
endmodule
`default_nettype wire

// file: bench/tb.sv
`include "hacp_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hacp_pkg::*;
  logic ref_clk, nrst, io_wr, io_rd, phase_err, fire;
  logic bus_rst_in, bus_rst_drive, host_irq, ccb_abandon, start_bus_cmd, start_bios_cmd;
  logic [1:0] io_addr;
  hacp_byte_t io_wdata, io_rdata, v, op;
  int miscompares, n_tests, n_drop, n_bus, n_bios;
  // opcode, parameter count, reply count
  logic [15:0] ops [27] = '{16'h0000, 16'h0300, 16'h0404, 16'h0510, 16'h0640, 16'h0710,
    16'h0810, 16'h0910, 16'h0A08, 16'h0B03, 16'h0C20, 16'h0D14, 16'h1A30, 16'h1B30,
    16'h1C30, 16'h1D30, 16'h1F11, 16'h2000, 16'h2120, 16'h2230, 16'h2330, 16'h2410,
    16'h2500, 16'h2600, 16'h2700, 16'h2802, 16'h2920};
  hacp_byte_t bad [4] = '{8'h0E, 8'h1E, 8'h2A, 8'hFF};
  hacp_byte_t inq [4] = '{`HACP_INQ_BOARD, `HACP_INQ_OPTION, `HACP_INQ_REV_HI, `HACP_INQ_REV_LO};
  hacp_core dut_u (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .bus_rst_in(bus_rst_in),
    .phase_err(phase_err), .bus_rst_drive(bus_rst_drive), .host_irq(host_irq),
    .ccb_abandon(ccb_abandon), .start_bus_cmd(start_bus_cmd), .start_bios_cmd(start_bios_cmd));
  hacp_bus_dev bus_u (.ref_clk(ref_clk), .bus_rst_drive(bus_rst_drive), .fire(fire),
    .bus_rst_in(bus_rst_in));
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // count the core's event pulses
  always @(posedge ref_clk) begin
    if (ccb_abandon === 1'b1) n_drop++;
    if (start_bus_cmd === 1'b1) n_bus++;
    if (start_bios_cmd === 1'b1) n_bios++;
  end
  // ------------------------------------------------------------
  // host port tasks
  // ------------------------------------------------------------
  task automatic chk(input hacp_byte_t got, input hacp_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input hacp_byte_t d);
    @(negedge ref_clk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output hacp_byte_t d);
    @(negedge ref_clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge ref_clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // poll one bit; 1250 reads span 100 us
  task automatic poll(input logic [1:0] a, input int b, input logic val);
    hacp_byte_t d;
    for (int i = 0; i < 1250; i++) begin
      rd(a, d);
      if (d[b] === val) break;
    end
    if (d[b] !== val) begin
      miscompares++;
      $display("BAD %0t poll timed out", $time);
    end
  endtask
  task automatic cmd(input hacp_byte_t b);
    poll(2'h0, `HACP_ST_CMD_FULL, 1'b0);
    wr(2'h1, b);
  endtask
  // opcodes other than the two start commands wait for idle
  task automatic opc(input hacp_byte_t b);
    if (b != `HACP_OP_START_BUS && b != `HACP_OP_START_BIOS) poll(2'h0, `HACP_ST_IDLE, 1'b1);
    cmd(b);
  endtask
  task automatic get(input hacp_byte_t e, input logic last);
    hacp_byte_t d;
    poll(2'h0, `HACP_ST_DIN_FULL, 1'b1);
    rd(2'h1, d);
    chk(d, e);
    rd(2'h0, d);
    if (last) chk(d & 8'h04, 8'h00);
  endtask
  // wait for completion, check status, then clear the flags
  task automatic done(input hacp_byte_t st);
    hacp_byte_t d;
    poll(2'h2, `HACP_IF_CMD_DONE, 1'b1);
    rd(2'h2, d);
    chk(d, 8'h84);
    chk({7'h00, host_irq}, 8'h01);
    rd(2'h0, d);
    chk(d, st);
    wr(2'h0, 8'h20);
    rd(2'h2, d);
    chk({d[7:1], host_irq}, 8'h00);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #(60000 * 40);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {io_wr, io_rd, io_addr, io_wdata, phase_err, fire} = '0;
    {miscompares, n_tests, n_drop, n_bus, n_bios} = '0;
    nrst = 1'b0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    chk({7'h00, bus_rst_drive}, 8'h01);
    poll(2'h0, `HACP_ST_SELF_TEST, 1'b0);
    rd(2'h0, v);
    chk(v, 8'h30);
    chk({7'h00, bus_rst_drive}, 8'h00);
    $display("test reset done");
    foreach (ops[k]) begin
      op = ops[k][15:8];
      opc(op);
      repeat (ops[k][7:4]) cmd(8'hA5);
      for (int j = 0; j < ops[k][3:0]; j++)
        get(op == 8'h04 ? inq[j] : (op == 8'h1F ? 8'hA5 : 8'h00), j == ops[k][3:0] - 1);
      done(8'h30);
    end
    foreach (bad[k]) begin
      opc(bad[k]);
      done(8'h31);
    end
    $display("test opcodes done");
    opc(`HACP_OP_START_BUS);
    done(8'h31);
    opc(`HACP_OP_MBX_INIT);
    repeat (4) cmd(8'h00);
    done(8'h31);
    opc(`HACP_OP_MBX_INIT);
    cmd(8'h01);
    repeat (3) cmd(8'h10);
    done(8'h10);
    opc(`HACP_OP_START_BUS);
    opc(`HACP_OP_START_BIOS);
    repeat (20) @(negedge ref_clk);
    chk(n_bus[7:0], 8'h01);
    chk(n_bios[7:0], 8'h01);
    rd(2'h2, v);
    chk(v, 8'h00);
    $display("test mailbox done");
    @(negedge ref_clk);
    fire = 1'b1;
    @(negedge ref_clk);
    fire = 1'b0;
    poll(2'h2, `HACP_IF_BUS_RST_DET, 1'b1);
    rd(2'h2, v);
    chk(v, 8'h88);
    chk({7'h00, host_irq}, 8'h01);
    rd(2'h0, v);
    chk(v & 8'h20, 8'h00);
    chk(n_drop[7:0], 8'h00);
    wr(2'h0, 8'h20);
    $display("test foreign reset done");
    wr(2'h0, 8'h40);
    poll(2'h0, `HACP_ST_IDLE, 1'b1);
    rd(2'h0, v);
    chk(v, 8'h30);
    chk(n_drop[7:0], 8'h01);
    chk({7'h00, bus_rst_drive}, 8'h00);
    opc(`HACP_OP_NOP);
    done(8'h30);
    $display("test soft reset done");
    @(negedge ref_clk);
    phase_err = 1'b1;
    @(negedge ref_clk);
    phase_err = 1'b0;
    poll(2'h2, `HACP_IF_BUS_RST_DET, 1'b1);
    chk({7'h00, bus_rst_drive}, 8'h01);
    wr(2'h0, 8'h20);
    repeat (700) @(negedge ref_clk);
    chk({7'h00, bus_rst_drive}, 8'h00);
    $display("test phase error done");
    wr(2'h0, 8'h80);
    rd(2'h0, v);
    chk(v & 8'h80, 8'h80);
    chk({7'h00, bus_rst_drive}, 8'h01);
    poll(2'h0, `HACP_ST_SELF_TEST, 1'b0);
    rd(2'h0, v);
    chk(v, 8'h30);
    chk(n_drop[7:0], 8'h02);
    $display("test hard reset done");
    stop_test();
  end
endmodule
`default_nettype wire
